/* File: core/timer16_oc_consts.vh */
/*
 * constants for the 16-bit timer output compare block: register offsets,
 * field positions, mode codes and reset values.
 * assumes a classic wishbone slave with 32-bit data, byte addresses.
 */
//
// Overview of operation
// R1: counter compared each channel, flag next tick
// R2: enabled flag requests irq, cleared by ack/one
// R3: channel a may define counter top
// R4: pwm modes double buffer, normal/ctc direct
// R5: cpu writes buffer or active register
// R6: compare value changes only by cpu writes
// R7: high byte staged, low write commits both
// R8: force strobe updates output, no flag/clear
// R9: counter write blocks matches next tick
// R10: software avoids writing top in pwm
// R11: output latch survives waveform mode changes
// R12: output action unbuffered, used next match
// R13: reset clears every output latch
// R14: nonzero action overrides port value on pin
// R15: output action never touches input capture
// R16: action zero leaves latch unchanged
// R17: action bits never alter counting sequence
// R18: normal mode counts up, wraps to zero
// R19: normal overflow flag set when zero, hardware-set only
// R20: ctc clears on compare a or capture
// R21: counter writable anytime in normal mode
// R22: cpu counter write beats clear or count
// R23: ctc overflow flag set on max rollover
// R24: matches, counts, flags only on tick enable
`ifndef TIMER16_OC_CONSTS_VH
`define TIMER16_OC_CONSTS_VH

// ------------------------------------------------------------
// register word addresses (byte address bits [4:2])
// ------------------------------------------------------------
`define REG_TIMER_CONTROL_A 3'h0
`define REG_TIMER_CONTROL_C 3'h1
`define REG_TIMER_COUNT 3'h2
`define REG_COMPARE_VALUE_A 3'h3
`define REG_COMPARE_VALUE_B 3'h4
`define REG_CAPTURE_VALUE 3'h5
`define REG_TIMER_FLAG 3'h6
`define REG_TIMER_IRQ_MASK 3'h7

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTLA_WGM_LSB 0
`define CTLA_WGM_MSB 3
`define CTLA_ACT_A_LSB 4
`define CTLA_ACT_A_MSB 5
`define CTLA_ACT_B_LSB 6
`define CTLA_ACT_B_MSB 7
`define CTLA_PORT_A_BIT 8
`define CTLA_PORT_B_BIT 9
`define CTLA_DIR_A_BIT 10
`define CTLA_DIR_B_BIT 11
`define CTLC_FORCE_A_BIT 0
`define CTLC_FORCE_B_BIT 1
`define FLAG_OVF_BIT 0
`define FLAG_CMP_A_BIT 1
`define FLAG_CMP_B_BIT 2
`define CV_LOW_LANE 0
`define CV_HIGH_LANE 1

// ------------------------------------------------------------
// waveform modes and output actions
// ------------------------------------------------------------
`define WGM_NORMAL 4'h0
`define WGM_CTC_CMP 4'h4
`define WGM_CTC_CAP 4'hc
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_WORD16 16'h0000
`define RST_BYTE 8'h00
`define COUNT_MAX 16'hffff
`define COUNT_ONE 16'h0001

`endif

/* File: core/timer16_output_compare_waveform.v */
/*
 * output compare part of a 16-bit timer: comparators, match flags,
 * interrupt requests, staged 16-bit writes, forced compare, match
 * blocking after counter writes, output latches with pin override,
 * normal and clear-on-match counting.
 * assumes a classic wishbone master, a one-cycle tick enable from an
 * external prescaler, and an interrupt controller pulsing irq_ack.
 */
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`include "timer16_oc_consts.vh"

module timer16_output_compare_waveform #(
	parameter WIDTH = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire [2:0] adr_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	input wire [3:0] sel_i,
	input wire we_i,
	input wire cyc_i,
	input wire stb_i,
	output reg ack_o,
	input wire irq_ack_a_i,
	input wire irq_ack_b_i,
	input wire irq_ack_ovf_i,
	output reg irq_a_o,
	output reg irq_b_o,
	output reg irq_ovf_o,
	output reg pin_a_o,
	output reg pin_b_o,
	output reg pin_a_oe_o,
	output reg pin_b_oe_o
);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg [WIDTH-1:0] timer_count;
reg [WIDTH-1:0] compare_value [0:1];
reg [WIDTH-1:0] compare_buffer [0:1];
reg [WIDTH-1:0] capture_value;
reg [7:0] stage_high;
reg [11:0] timer_control_a;
reg [2:0] timer_flag_reg;
reg [2:0] timer_irq_mask_reg;
reg [1:0] compare_output_latch;
reg block_match;
wire [3:0] waveform_mode_select;
wire [1:0] output_action_select [0:1];
wire bus_go;
wire wr;
wire count_wr;
wire is_pwm;
wire [1:0] raw_match;
wire [1:0] match;
wire [1:0] force_compare_strobe;
wire ctc_top;
reg [WIDTH-1:0] next_count;

assign waveform_mode_select =
	timer_control_a[`CTLA_WGM_MSB:`CTLA_WGM_LSB];
assign output_action_select[0] =
	timer_control_a[`CTLA_ACT_A_MSB:`CTLA_ACT_A_LSB];
assign output_action_select[1] =
	timer_control_a[`CTLA_ACT_B_MSB:`CTLA_ACT_B_LSB];
assign bus_go = cyc_i & stb_i & ~ack_o;
assign wr = bus_go & we_i;
assign count_wr = wr && adr_i == `REG_TIMER_COUNT;
assign force_compare_strobe[0] = wr && adr_i == `REG_TIMER_CONTROL_C &&
	sel_i[0] && dat_i[`CTLC_FORCE_A_BIT];
assign force_compare_strobe[1] = wr && adr_i == `REG_TIMER_CONTROL_C &&
	sel_i[0] && dat_i[`CTLC_FORCE_B_BIT];

// every mode other than normal and the two ctc codes is a pwm mode
assign is_pwm = !(waveform_mode_select == `WGM_NORMAL ||
	waveform_mode_select == `WGM_CTC_CMP ||
	waveform_mode_select == `WGM_CTC_CAP); // R4

// ------------------------------------------------------------
// comparators
// ------------------------------------------------------------
genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : cmp
		// continuous equality against the active register
		assign raw_match[g] = timer_count == compare_value[g]; // R1
		// a counter write suppresses the next tick's match
		assign match[g] = raw_match[g] & tick_i & ~block_match; // R9 R24
	end
endgenerate

// top for ctc: channel a or capture value
assign ctc_top = tick_i & ~block_match &
	((waveform_mode_select == `WGM_CTC_CMP && raw_match[0]) ||
	(waveform_mode_select == `WGM_CTC_CAP &&
	timer_count == capture_value)); // R3 R20

// new output level for one action code
function new_level;
	input [1:0] act;
	input cur;
	begin
		case (act)
			`ACT_TOGGLE: new_level = ~cur;
			`ACT_CLEAR: new_level = 1'b0;
			`ACT_SET: new_level = 1'b1;
			default: new_level = cur; // R16
		endcase
	end
endfunction

// ------------------------------------------------------------
// counter next value
// ------------------------------------------------------------
// action bits are not inputs here, so they never shape counting
always @* begin
	next_count = timer_count; // R17
	if (count_wr) begin
		next_count[7:0] = sel_i[`CV_LOW_LANE] ? dat_i[7:0] :
			timer_count[7:0]; // R21 R22
		next_count[15:8] = sel_i[`CV_HIGH_LANE] ? dat_i[15:8] :
			timer_count[15:8];
	end else if (ctc_top)
		next_count = `RST_WORD16; // R20
	else if (tick_i)
		next_count = timer_count + `COUNT_ONE; // R18 R24
end

// ------------------------------------------------------------
// counter, block, flags
// ------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		timer_count <= `RST_WORD16;
		block_match <= 1'b0;
		timer_flag_reg <= 3'h0;
	end else begin
		timer_count <= next_count;
		// held until a tick consumes it, so a stopped timer still blocks
		if (count_wr)
			block_match <= 1'b1; // R9
		else if (tick_i)
			block_match <= 1'b0;
		// set beats software or acknowledge clear
		timer_flag_reg[`FLAG_CMP_A_BIT] <= match[0] |
			(timer_flag_reg[`FLAG_CMP_A_BIT] & ~irq_ack_a_i &
			~(wr && adr_i == `REG_TIMER_FLAG && sel_i[0] &&
			dat_i[`FLAG_CMP_A_BIT])); // R1 R2
		timer_flag_reg[`FLAG_CMP_B_BIT] <= match[1] |
			(timer_flag_reg[`FLAG_CMP_B_BIT] & ~irq_ack_b_i &
			~(wr && adr_i == `REG_TIMER_FLAG && sel_i[0] &&
			dat_i[`FLAG_CMP_B_BIT])); // R2
		// overflow only on a counted rollover max to zero
		timer_flag_reg[`FLAG_OVF_BIT] <=
			(tick_i && !count_wr && timer_count == `COUNT_MAX) |
			(timer_flag_reg[`FLAG_OVF_BIT] & ~irq_ack_ovf_i &
			~(wr && adr_i == `REG_TIMER_FLAG && sel_i[0] &&
			dat_i[`FLAG_OVF_BIT])); // R19 R23
	end
end

// ------------------------------------------------------------
// compare registers and byte staging
// ------------------------------------------------------------
generate
	for (g = 0; g < 2; g = g + 1) begin : cv
		always @(posedge clk_i) begin
			if (rst_i) begin
				compare_value[g] <= `RST_WORD16;
				compare_buffer[g] <= `RST_WORD16;
			end else begin
				// low-lane write commits the staged high byte too
				if (wr && adr_i == `REG_COMPARE_VALUE_A + g &&
					sel_i[`CV_LOW_LANE]) begin
					if (is_pwm)
						compare_buffer[g] <= {stage_high,
							dat_i[7:0]}; // R5 R7
					else
						compare_value[g] <= {stage_high,
							dat_i[7:0]}; // R5 R6
				end
				// pwm update at bottom; the pwm counter is elsewhere
				if (is_pwm && tick_i && timer_count == `RST_WORD16)
					compare_value[g] <= compare_buffer[g]; // R4
			end
		end
	end
endgenerate

// one staging latch shared by the compare and capture value writes; counter writes use byte lanes directly
always @(posedge clk_i) begin
	if (rst_i)
		stage_high <= `RST_BYTE;
	else if (wr && sel_i[`CV_HIGH_LANE] &&
		(adr_i == `REG_COMPARE_VALUE_A ||
		adr_i == `REG_COMPARE_VALUE_B ||
		adr_i == `REG_CAPTURE_VALUE))
		stage_high <= dat_i[15:8]; // R7
end

// ------------------------------------------------------------
// control, mask, capture top
// ------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		timer_control_a <= 12'h000;
		timer_irq_mask_reg <= 3'h0;
		capture_value <= `RST_WORD16;
	end else if (wr) begin
		// action bits take effect immediately, unbuffered
		if (adr_i == `REG_TIMER_CONTROL_A) begin
			if (sel_i[0])
				timer_control_a[7:0] <= dat_i[7:0]; // R12
			if (sel_i[1])
				timer_control_a[11:8] <= dat_i[11:8];
		end
		if (adr_i == `REG_TIMER_IRQ_MASK && sel_i[0])
			timer_irq_mask_reg <= dat_i[2:0];
		// capture value only holds a top here, no capture logic
		if (adr_i == `REG_CAPTURE_VALUE && sel_i[`CV_LOW_LANE])
			capture_value <= {stage_high, dat_i[7:0]}; // R15
	end
end

// ------------------------------------------------------------
// output latches and pins
// ------------------------------------------------------------
generate
	for (g = 0; g < 2; g = g + 1) begin : ol
		// not touched by mode writes, so the level survives changes
		always @(posedge clk_i) begin
			if (rst_i)
				compare_output_latch[g] <= 1'b0; // R13
			else if ((match[g] ||
				(force_compare_strobe[g] && !is_pwm)) && !is_pwm)
				compare_output_latch[g] <= new_level(
					output_action_select[g],
					compare_output_latch[g]); // R8 R11 R12
		end
	end
endgenerate

// pins and irqs all registered; override when action nonzero
always @(posedge clk_i) begin
	if (rst_i) begin
		pin_a_o <= 1'b0;
		pin_b_o <= 1'b0;
		pin_a_oe_o <= 1'b0;
		pin_b_oe_o <= 1'b0;
		irq_a_o <= 1'b0;
		irq_b_o <= 1'b0;
		irq_ovf_o <= 1'b0;
	end else begin
		pin_a_o <= (output_action_select[0] != `ACT_NONE) ?
			compare_output_latch[0] :
			timer_control_a[`CTLA_PORT_A_BIT]; // R14
		pin_b_o <= (output_action_select[1] != `ACT_NONE) ?
			compare_output_latch[1] :
			timer_control_a[`CTLA_PORT_B_BIT]; // R14
		pin_a_oe_o <= timer_control_a[`CTLA_DIR_A_BIT]; // R14
		pin_b_oe_o <= timer_control_a[`CTLA_DIR_B_BIT];
		irq_a_o <= timer_flag_reg[`FLAG_CMP_A_BIT] &
			timer_irq_mask_reg[`FLAG_CMP_A_BIT] & ~irq_ack_a_i; // R2
		irq_b_o <= timer_flag_reg[`FLAG_CMP_B_BIT] &
			timer_irq_mask_reg[`FLAG_CMP_B_BIT] & ~irq_ack_b_i; // R2
		irq_ovf_o <= timer_flag_reg[`FLAG_OVF_BIT] &
			timer_irq_mask_reg[`FLAG_OVF_BIT] & ~irq_ack_ovf_i;
	end
end

// ------------------------------------------------------------
// wishbone slave: one registered ack a cycle after the request, zero for unmapped lanes
// ------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		ack_o <= 1'b0;
		dat_o <= 32'h00000000;
	end else begin
		ack_o <= bus_go;
		dat_o <= 32'h00000000;
		if (bus_go && !we_i) begin
			case (adr_i)
				`REG_TIMER_CONTROL_A: dat_o[11:0] <= timer_control_a;
				`REG_TIMER_COUNT: dat_o[15:0] <= timer_count;
				// reads the buffer in pwm modes, never the latch
				`REG_COMPARE_VALUE_A: dat_o[15:0] <= is_pwm ?
					compare_buffer[0] : compare_value[0]; // R6
				`REG_COMPARE_VALUE_B: dat_o[15:0] <= is_pwm ?
					compare_buffer[1] : compare_value[1]; // R6
				`REG_CAPTURE_VALUE: dat_o[15:0] <= capture_value;
				`REG_TIMER_FLAG: dat_o[2:0] <= timer_flag_reg;
				`REG_TIMER_IRQ_MASK: dat_o[2:0] <= timer_irq_mask_reg;
				default: dat_o <= 32'h00000000;
			endcase
		end
	end
end

endmodule // timer16_output_compare_waveform

/* File: dv/cpu_bus_model.sv */
/*
 * cpu side of the timer block: classic wishbone single cycles and
 * interrupt service pulses.
 * assumes the slave answers within 20 cycles and the bench top is testbench.
 */
`timescale 1ns/1ns
module cpu_bus_model (
	input wire clk_i,
	input wire ack_i,
	input wire [31:0] rdat_i,
	output reg cyc_o,
	output reg stb_o,
	output reg we_o,
	output reg [2:0] adr_o,
	output reg [3:0] sel_o,
	output reg [31:0] wdat_o,
	output reg [2:0] irq_ack_o
);
	// idle bus at time zero
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o, irq_ack_o} = '0;
	end

	// one cycle, held until ack; released lines are inverted so stale
	// values never pass for a live request
	task automatic xfer(input bit w, input [2:0] a, input [3:0] s,
		input [31:0] d, output [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, s, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 20);
		if (ack_i !== 1'b1) begin
			testbench.error_cnt++;
			testbench.end_of_test();
		end
		q = rdat_i;
		{cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b00, ~w, ~a, ~s, ~d};
	endtask

	// interrupt serviced: one-cycle pulse per selected source
	task automatic service(input [2:0] m);
		@(posedge clk_i);
		irq_ack_o <= m;
		@(posedge clk_i);
		irq_ack_o <= 3'h0;
	endtask
endmodule // cpu_bus_model

/* File: dv/timer16_oc_assertions.sv */
/*
 * port checks for the timer compare block.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module timer16_oc_checker (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire [2:0] adr_i,
	input wire [31:0] dat_o,
	input wire we_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire irq_ack_a_i,
	input wire irq_ack_ovf_i,
	input wire irq_a_o,
	input wire irq_ovf_o,
	input wire pin_a_o,
	input wire pin_a_oe_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a pin may only move after a tick or a bus write reached the block
	wire ctl_wr = cyc_i && stb_i && we_i && adr_i == 3'h0;
	wire cause = tick_i || (cyc_i && we_i);
	sequence s_taken;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_pulse;
		ack_o ##1 !ack_o;
	endsequence

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_ack_one: assert property (s_taken |=> s_pulse)
		else $error("ack not a single pulse after request");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_read_idle: assert property (!(ack_o && !we_i) |-> dat_o == 32'h0)
		else $error("read data outside read ack");
	a_irq_a_clear: assert property (irq_ack_a_i |=> !irq_a_o)
		else $error("irq a stays after service");
	a_irq_ovf_clear: assert property (irq_ack_ovf_i |=> !irq_ovf_o)
		else $error("irq ovf stays after service");
	a_reset_quiet: assert property ($fell(rst_i) |->
		!(pin_a_o || pin_a_oe_o || irq_a_o || ack_o))
		else $error("outputs not cleared by reset");
	a_oe_cause: assert property ($changed(pin_a_oe_o) |->
		$past(ctl_wr) || $past(ctl_wr, 2))
		else $error("pin enable moved without control write");
	a_pin_cause: assert property ($changed(pin_a_o) |->
		$past(cause) || $past(cause, 2))
		else $error("pin moved without tick or write");
endmodule // timer16_oc_checker

bind timer16_output_compare_waveform timer16_oc_checker i_chk (.*);

/* File: dv/testbench.sv */
/*
 * self-checking bench: register table, forced compare, clear-on-match,
 * match blocking, overflow and a mid-run reset.
 * assumes cpu_bus_model for bus cycles and a 100 MHz clock.
 */
`timescale 1ns/1ns
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tick_i = 1'b0;
	wire [31:0] wdat, rdat;
	wire [3:0] sel;
	wire [2:0] adr, iack;
	wire cyc, stb, we, ack, irq_a, irq_ovf, pin_a, oe_a;
	wire irq_b, pin_b, oe_b;
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] q;
	// row: {write, word, lanes} then write data or expected read
	logic [39:0] rows [16] = '{40'ha3ffff1234, 40'h2000001234,
		40'hb20000ab00, 40'hb1000000cd, 40'h300000abcd, 40'hc300005678,
		40'h400000ab78, 40'hc100000011, 40'h4000005611, 40'hffffffffff,
		40'h7000000007, 40'h1000000000, 40'h8fffffffff, 40'h0000000fff,
		40'h6000000000, 40'h5000000000};

	always #5 clk_i = ~clk_i;

	cpu_bus_model cpu (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.wdat_o(wdat), .irq_ack_o(iack));
	timer16_output_compare_waveform i_timer16_output_compare_waveform (
		.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i), .adr_i(adr),
		.dat_i(wdat), .dat_o(rdat), .sel_i(sel), .we_i(we), .cyc_i(cyc),
		.stb_i(stb), .ack_o(ack), .irq_ack_a_i(iack[0]),
		.irq_ack_b_i(iack[1]), .irq_ack_ovf_i(iack[2]), .irq_a_o(irq_a),
		.irq_b_o(irq_b), .irq_ovf_o(irq_ovf), .pin_a_o(pin_a),
		.pin_b_o(pin_b), .pin_a_oe_o(oe_a), .pin_b_oe_o(oe_b));

	task automatic chk(input string what, input [31:0] exp, input [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pin(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic wr(input [2:0] a, input [3:0] s, input [31:0] d);
		cpu.xfer(1'b1, a, s, d, q);
	endtask
	task automatic rd_chk(input string what, input [2:0] a, input [31:0] e);
		cpu.xfer(1'b0, a, 4'hf, 32'h0, q);
		chk(what, e, q);
	endtask
	// one-cycle tick pulses, then let the registered outputs settle
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_i);
			tick_i <= 1'b1;
			@(posedge clk_i);
			tick_i <= 1'b0;
		end
		repeat (2) @(posedge clk_i);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// counter is only loaded in non-pwm modes, never with a pwm top
		foreach (rows[i]) begin
			if (rows[i][39])
				wr(rows[i][38:36], rows[i][35:32], rows[i][31:0]);
			else
				rd_chk("reg", rows[i][38:36], rows[i][31:0]);
		end
		$display("register table done");
		wr(3'h0, 4'h3, 32'h00000430);
		wr(3'h1, 4'h1, 32'h00000001);
		repeat (2) @(posedge clk_i);
		chk_pin("pin a", 1'b1, pin_a);
		chk_pin("oe a", 1'b1, oe_a);
		chk_pin("pin b", 1'b0, pin_b);
		chk_pin("oe b", 1'b0, oe_b);
		chk_pin("irq b", 1'b0, irq_b);
		rd_chk("flags", 3'h6, 32'h0);
		$display("forced compare done");
		wr(3'h2, 4'h3, 32'h0);
		wr(3'h3, 4'h2, 32'h0);
		wr(3'h3, 4'h1, 32'h3);
		wr(3'h0, 4'h3, 32'h00000414);
		chk_pin("pin a", 1'b1, pin_a);
		ticks(4);
		chk_pin("pin a", 1'b0, pin_a);
		chk_pin("irq a", 1'b1, irq_a);
		rd_chk("flags", 3'h6, 32'h2);
		rd_chk("count", 3'h2, 32'h0);
		wr(3'h6, 4'h1, 32'h2);
		rd_chk("flags", 3'h6, 32'h0);
		$display("clear on match done");
		wr(3'h2, 4'h3, 32'h3);
		ticks(1);
		rd_chk("flags", 3'h6, 32'h0);
		rd_chk("count", 3'h2, 32'h4);
		$display("match blocking done");
		wr(3'h0, 4'h3, 32'h00000400);
		wr(3'h2, 4'h3, 32'h0000fffe);
		ticks(2);
		rd_chk("flags", 3'h6, 32'h1);
		chk_pin("irq ovf", 1'b1, irq_ovf);
		rd_chk("count", 3'h2, 32'h0);
		cpu.service(3'h7);
		rd_chk("flags", 3'h6, 32'h0);
		$display("overflow done");
		wr(3'h0, 4'h3, 32'h00000430);
		wr(3'h1, 4'h1, 32'h1);
		repeat (2) @(posedge clk_i);
		chk_pin("pin a", 1'b1, pin_a);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_pin("pin a", 1'b0, pin_a);
		rd_chk("control", 3'h0, 32'h0);
		$display("reset done");
		end_of_test();
	end
endmodule // testbench
